/* File: hdl/csd_pkg.sv */
// Constants for the capture stop-delay and field-format block.
// Assumes a 32-bit AXI4-Lite register port and a 32-channel probe pod.
package csd_pkg;
   // Register byte offsets
   localparam int CSD_AW = 8;
   localparam logic [7:0] CSD_CTRL = 8'h00;
   localparam logic [7:0] CSD_DELAY = 8'h04;
   localparam logic [7:0] CSD_START = 8'h08;
   localparam logic [7:0] CSD_STAT = 8'h0c;
   localparam logic [7:0] CSD_PRE = 8'h10;
   localparam logic [7:0] CSD_TPOS = 8'h14;
   localparam logic [7:0] CSD_TLINE = 8'h20;
   localparam logic [7:0] CSD_FIELD = 8'h40;
   // Field positions
   localparam int CSD_CTRL_ARM = 0;
   localparam int CSD_CTRL_STOP = 1;
   localparam int CSD_CTRL_MODE = 2;
   localparam int CSD_START_BEFORE = 31;
   localparam int CSD_STAT_ERR = 4;
   localparam int CSD_TL_BLANK = 7;
   localparam int CSD_F_HI = 8;
   localparam int CSD_F_LO = 16;
   localparam int CSD_F_SENSE = 24;
   // Reset values
   localparam logic [31:0] CSD_TLINE_RST = 32'h8080_8080;
   localparam logic [3:0] CSD_BASE_RST = 4'hf;
   // Recording widths and their delay quanta
   typedef enum logic [1:0] {CSD_W4 = 2'b00, CSD_W8 = 2'b01, CSD_W16 = 2'b10, CSD_W32 = 2'b11} csd_mode_t;
   localparam logic [31:0] CSD_Q4 = 32'd40;
   localparam logic [31:0] CSD_Q8 = 32'd20;
   localparam logic [31:0] CSD_Q16 = 32'd10;
   localparam logic [31:0] CSD_Q32 = 32'd5;
   // Field base codes
   localparam logic [3:0] CSD_BASE_ASC = 4'ha;
   localparam logic [3:0] CSD_BASE_BIN = 4'hb;
   localparam logic [3:0] CSD_BASE_OCT = 4'hc;
   localparam logic [3:0] CSD_BASE_DEC = 4'hd;
   localparam logic [3:0] CSD_BASE_HEX = 4'he;
   localparam logic [3:0] CSD_BASE_OFF = 4'hf;
   // Sizes and timing counts
   localparam int CSD_LINES = 12;
   localparam int CSD_FIELDS = 8;
   localparam int CSD_FMAX = 22;
   localparam int CSD_PIPE_CLKS = 17;
   localparam logic [1:0] CSD_STOP_CLKS = 2'd2;
   localparam logic [1:0] CSD_OKAY = 2'b00;
   localparam logic [1:0] CSD_SLVERR = 2'b10;
   // Acquisition states
   typedef enum logic [2:0] {
      CSD_IDLE = 3'b000, CSD_WAIT = 3'b001, CSD_POST = 3'b010, CSD_HALT = 3'b011, CSD_DONE = 3'b100
   } csd_state_t;
endpackage

/* File: hdl/csd_field_xtr.sv */
// One state field: slices consecutive channels and applies the data sense.
// Assumes the caller refuses high below low and over-wide fields.
`timescale 1ns/1ps
`default_nettype none
module csd_field_xtr (
   // Sample and field bounds
   input wire logic [31:0] smp,
   input wire logic [4:0] lo,
   input wire logic [4:0] hi,
   input wire logic sense_complemented,
   // Field value, low channel in bit 0
   output logic [21:0] val
);
   import csd_pkg::*;
   logic [31:0] sh;
   logic [31:0] msk;
   logic [5:0] wid;

   // Shift down, mask to width, complement only inside the mask
   always_comb begin
      wid = 6'(hi - lo) + 6'd1; // R10
      sh = smp >> lo;
      msk = (32'h1 << wid) - 32'h1;
      if (sense_complemented) begin
         sh = ~sh; // R13
      end
      sh = sh & msk;
      val = sh[21:0]; // R11
   end
endmodule
`default_nettype wire

/* File: hdl/csd_capture.sv */
// Post-trigger storage control and display field formatting.
// Assumes async probe pins and trigger_event from logic on aclk,
// and a memory taking one write per cycle on mem_we.
// Notes on behaviour
// R1: After the trigger, samples are stored until the programmed delay of qualified clocks has passed.
// R2: The start position equals delay minus record depth, and writing either one sets the other.
// R3: The delay counter moves only on clocks that pass both clock and data qualification.
// R4: The sampled system must give 17 qualified clocks after the trigger, and reported positions allow for them.
// R5: A manual stop finishes storage after two further external clocks.
// R6: Only the post-trigger count is assured; pre-trigger samples are those taken, up to the depth.
// R7: The delay is a multiple of 40, 20, 10 or 5 for 4, 8, 16 or 32 channel recording.
// R8: Twelve timing lines each show one chosen channel, channels may repeat, and a blank line shows nothing.
// R9: Eight state fields each have a base, a high channel, a low channel and a data sense, and may overlap.
// R10: A field is the channels from low to high, low in bit 0, and high below low is refused.
// R11: No field is wider than 22 bits.
// R12: Base codes A to E give ASCII, binary, octal, decimal and hex, and F turns the field off.
// R13: Sense 0 is plain and 1 complements the field on state and trigger views, never on timing lines.
// R14: A down-counter loads the delay at the trigger, counts qualified clocks and ends memory writes at zero.
`timescale 1ns/1ps
`default_nettype none
module csd_capture #(
   parameter int DLY_W = 20,
   parameter int ADDR_W = 10,
   parameter int REC_DEPTH = 1000
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [csd_pkg::CSD_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [csd_pkg::CSD_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Probe pins, asynchronous
   input wire logic probe_clk,
   input wire logic clk_qual,
   input wire logic data_qual,
   input wire logic [31:0] probe_data,
   // Trigger from sequencer on aclk
   input wire logic trigger_event,
   // Acquisition memory
   output logic mem_we,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [31:0] mem_wdata,
   // Display views
   output logic [csd_pkg::CSD_LINES-1:0] timing_bits,
   output logic [csd_pkg::CSD_FIELDS*22-1:0] field_val,
   output logic [csd_pkg::CSD_FIELDS-1:0] field_on,
   output logic [csd_pkg::CSD_FIELDS*4-1:0] field_base,
   output logic acq_done
);
   import csd_pkg::*;

   // Refuse sizes the counters cannot hold
   initial begin
      if (REC_DEPTH < 2 || REC_DEPTH > (1 << ADDR_W) || DLY_W < 8 || DLY_W > 30) begin
         $error("csd_capture: unsupported depth or delay width");
      end
   end

   localparam logic [DLY_W-1:0] DEPTH_D = DLY_W'(REC_DEPTH);
   localparam logic [DLY_W-1:0] PIPE_D = DLY_W'(CSD_PIPE_CLKS);
   localparam logic [ADDR_W-1:0] LAST_A = ADDR_W'(REC_DEPTH - 1);
   localparam logic [ADDR_W-1:0] PIPE_A = ADDR_W'(CSD_PIPE_CLKS % REC_DEPTH);

   // Register file state
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [CSD_AW-1:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic arm_ff, stop_ff, err_ff;
   csd_mode_t mode_ff;
   logic [DLY_W-1:0] delay_ff;
   logic [7:0] tline_ff [CSD_LINES];
   logic [3:0] base_ff [CSD_FIELDS];
   logic [4:0] hi_ff [CSD_FIELDS];
   logic [4:0] lo_ff [CSD_FIELDS];
   logic sense_ff [CSD_FIELDS];
   // Acquisition state
   csd_state_t st_ff;
   logic [DLY_W-1:0] cnt_ff;
   logic [1:0] halt_ff;
   logic [ADDR_W-1:0] addr_ff, tpos_ff;
   logic [DLY_W-1:0] pre_ff;
   logic mem_we_ff;
   logic [31:0] mem_wdata_ff;
   // Pin synchronisers
   logic [31:0] dat_s1_ff, dat_s2_ff;
   logic pclk_s1_ff, pclk_s2_ff, pclk_d_ff;
   logic cq_s1_ff, cq_s2_ff, dq_s1_ff, dq_s2_ff;
   // Views
   logic [CSD_LINES-1:0] tbits_ff;
   logic [21:0] fval_ff [CSD_FIELDS];
   logic [21:0] fraw [CSD_FIELDS];

   // Write decode
   logic wr_go, wr_ok, rd_ok, ext_edge, qual_edge, store;
   logic [31:0] wv, rv;
   logic [4:0] nhi, nlo;
   logic [2:0] widx;
   assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
   assign widx = awaddr_ff[4:2];
   assign nhi = wv[CSD_F_HI +: 5];
   assign nlo = wv[CSD_F_LO +: 5];

   // Byte-lane merge into an old register value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Round a delay down to the step of the recording width
   function automatic logic [DLY_W-1:0] quant(input logic [31:0] v, input csd_mode_t m);
      logic [31:0] q;
      case (m)
         CSD_W4: q = CSD_Q4;
         CSD_W8: q = CSD_Q8;
         CSD_W16: q = CSD_Q16;
         default: q = CSD_Q32;
      endcase
      return DLY_W'((v / q) * q); // R7
   endfunction

   // Start position as magnitude with a before flag
   function automatic logic [31:0] start_of(input logic [DLY_W-1:0] d);
      logic [31:0] r;
      r = 32'h0;
      if (d >= DEPTH_D) begin
         r[DLY_W-1:0] = d - DEPTH_D; // R2
      end else begin
         r[DLY_W-1:0] = DEPTH_D - d;
         r[CSD_START_BEFORE] = 1'b1;
      end
      return r;
   endfunction

   // Addressed register value, for merging and reads
   function automatic logic [31:0] reg_at(input logic [CSD_AW-1:0] a, output logic ok);
      logic [31:0] r;
      logic [2:0] i;
      r = 32'h0;
      ok = 1'b1;
      i = a[4:2];
      if (a >= CSD_FIELD && a < CSD_FIELD + 8'h20 && a[1:0] == 2'b00) begin
         r[3:0] = base_ff[i];
         r[CSD_F_HI +: 5] = hi_ff[i];
         r[CSD_F_LO +: 5] = lo_ff[i];
         r[CSD_F_SENSE] = sense_ff[i];
      end else if (a >= CSD_TLINE && a < CSD_TLINE + 8'h0c && a[1:0] == 2'b00) begin
         r = {tline_ff[i[1:0]*4+3], tline_ff[i[1:0]*4+2], tline_ff[i[1:0]*4+1], tline_ff[i[1:0]*4]};
      end else begin
         case (a)
            CSD_CTRL: r[CSD_CTRL_MODE +: 2] = mode_ff;
            CSD_DELAY: r[DLY_W-1:0] = delay_ff;
            CSD_START: r = start_of(delay_ff);
            CSD_STAT: r[4:0] = {err_ff, st_ff == CSD_DONE, st_ff == CSD_HALT, st_ff == CSD_POST, st_ff == CSD_WAIT};
            CSD_PRE: r[DLY_W-1:0] = pre_ff;
            CSD_TPOS: r[ADDR_W-1:0] = tpos_ff;
            default: ok = 1'b0;
         endcase
      end
      return r;
   endfunction

   always_comb begin
      wv = merge(reg_at(awaddr_ff, wr_ok), wdata_ff, wstrb_ff);
      rv = reg_at(araddr, rd_ok);
   end

   // Write address and data, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         awaddr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end else begin
         if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            awaddr_ff <= awaddr;
         end else if (wr_go) begin
            awready_ff <= 1'b1;
         end
         if (wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end else if (wr_go) begin
            wready_ff <= 1'b1;
         end
      end
   end

   // Write response, one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= CSD_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_ok ? CSD_OKAY : CSD_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Read channel, data one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= CSD_OKAY;
      end else if (arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rv;
         rresp_ff <= rd_ok ? CSD_OKAY : CSD_SLVERR;
      end else if (rvalid_ff && rready) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // Control, delay and start; either write fixes the other
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm_ff <= 1'b0;
         stop_ff <= 1'b0;
         mode_ff <= CSD_W32;
         delay_ff <= '0;
      end else begin
         arm_ff <= wr_go && awaddr_ff == CSD_CTRL && wv[CSD_CTRL_ARM];
         stop_ff <= wr_go && awaddr_ff == CSD_CTRL && wv[CSD_CTRL_STOP];
         if (wr_go && awaddr_ff == CSD_CTRL) begin
            mode_ff <= csd_mode_t'(wv[CSD_CTRL_MODE +: 2]);
            delay_ff <= quant(32'(delay_ff), csd_mode_t'(wv[CSD_CTRL_MODE +: 2])); // R7
         end else if (wr_go && awaddr_ff == CSD_DELAY) begin
            delay_ff <= quant(32'(wv[DLY_W-1:0]), mode_ff); // R2
         end else if (wr_go && awaddr_ff == CSD_START) begin
            if (!wv[CSD_START_BEFORE]) begin
               delay_ff <= quant(32'(DEPTH_D) + 32'(wv[DLY_W-1:0]), mode_ff); // R2
            end else if (wv[DLY_W-1:0] < DEPTH_D) begin
               delay_ff <= quant(32'(DEPTH_D - wv[DLY_W-1:0]), mode_ff); // R2
            end else begin
               delay_ff <= '0;
            end
         end
      end
   end

   // Timing line map; channels may repeat
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < CSD_LINES; i++) begin
            tline_ff[i] <= CSD_TLINE_RST[7:0];
         end
      end else if (wr_go && awaddr_ff >= CSD_TLINE && awaddr_ff < CSD_TLINE + 8'h0c) begin
         for (int b = 0; b < 4; b++) begin
            tline_ff[widx[1:0]*4+b] <= wv[b*8 +: 8]; // R8
         end
      end
   end

   // Field setup; bad ranges refused and flagged, set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_ff <= 1'b0;
         for (int i = 0; i < CSD_FIELDS; i++) begin
            base_ff[i] <= CSD_BASE_RST;
            hi_ff[i] <= 5'h0;
            lo_ff[i] <= 5'h0;
            sense_ff[i] <= 1'b0;
         end
      end else if (wr_go && awaddr_ff >= CSD_FIELD && awaddr_ff < CSD_FIELD + 8'h20) begin
         if (nhi < nlo || 32'(nhi - nlo) >= CSD_FMAX) begin
            err_ff <= 1'b1; // R10 R11
         end else begin
            base_ff[widx] <= (wv[3:0] < CSD_BASE_ASC) ? CSD_BASE_OFF : wv[3:0]; // R12
            hi_ff[widx] <= nhi; // R9
            lo_ff[widx] <= nlo; // R9
            sense_ff[widx] <= wv[CSD_F_SENSE]; // R13
         end
      end else if (wr_go && awaddr_ff == CSD_STAT && wv[CSD_STAT_ERR] && wstrb_ff[0]) begin
         err_ff <= 1'b0;
      end
   end

   // Two flops on every pin before use
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dat_s1_ff <= 32'h0;
         dat_s2_ff <= 32'h0;
         {pclk_s1_ff, pclk_s2_ff, pclk_d_ff} <= 3'b000;
         {cq_s1_ff, cq_s2_ff, dq_s1_ff, dq_s2_ff} <= 4'h0;
      end else begin
         dat_s1_ff <= probe_data;
         dat_s2_ff <= dat_s1_ff;
         pclk_s1_ff <= probe_clk;
         pclk_s2_ff <= pclk_s1_ff;
         pclk_d_ff <= pclk_s2_ff;
         cq_s1_ff <= clk_qual;
         cq_s2_ff <= cq_s1_ff;
         dq_s1_ff <= data_qual;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   // Rising external clock, qualified by both pins
   assign ext_edge = pclk_s2_ff && !pclk_d_ff;
   assign qual_edge = ext_edge && cq_s2_ff && dq_s2_ff; // R3
   assign store = qual_edge && (st_ff == CSD_WAIT || (st_ff == CSD_POST && cnt_ff != '0) || st_ff == CSD_HALT);

   // Acquisition sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= CSD_IDLE;
      end else begin
         case (st_ff)
            CSD_IDLE, CSD_DONE: begin
               if (arm_ff) begin
                  st_ff <= CSD_WAIT;
               end
            end
            CSD_WAIT: begin
               if (stop_ff) begin
                  st_ff <= CSD_HALT;
               end else if (trigger_event) begin
                  st_ff <= CSD_POST;
               end
            end
            CSD_POST: begin
               if (stop_ff) begin
                  st_ff <= CSD_HALT;
               end else if (cnt_ff == '0) begin
                  st_ff <= CSD_DONE; // R1
               end
            end
            CSD_HALT: begin
               if (ext_edge && halt_ff == 2'd1) begin
                  st_ff <= CSD_DONE; // R5
               end
            end
            default: st_ff <= CSD_IDLE;
         endcase
      end
   end

   // Delay down-counter; trigger pipeline already spent when it loads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= '0;
      end else if (st_ff == CSD_WAIT && trigger_event) begin
         cnt_ff <= (delay_ff > PIPE_D) ? delay_ff - PIPE_D : '0; // R14 R4
      end else if (st_ff == CSD_POST && qual_edge && cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1; // R14 R3
      end
   end

   // Manual stop: two more external clocks, not qualified ones
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halt_ff <= 2'd0;
      end else if (st_ff != CSD_HALT) begin
         halt_ff <= CSD_STOP_CLKS; // R5
      end else if (ext_edge) begin
         halt_ff <= halt_ff - 2'd1;
      end
   end

   // Pre-trigger tally, saturating at the record depth
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_ff <= '0;
      end else if (arm_ff && (st_ff == CSD_IDLE || st_ff == CSD_DONE)) begin
         pre_ff <= '0;
      end else if (store && st_ff == CSD_WAIT && pre_ff < DEPTH_D) begin
         pre_ff <= pre_ff + 1'b1; // R6
      end
   end

   // Circular write port and trigger position, backed off by the pipeline
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_ff <= '0;
         tpos_ff <= '0;
         mem_we_ff <= 1'b0;
         mem_wdata_ff <= 32'h0;
      end else begin
         mem_we_ff <= store; // R1 R14
         mem_wdata_ff <= dat_s2_ff;
         if (arm_ff && (st_ff == CSD_IDLE || st_ff == CSD_DONE)) begin
            addr_ff <= '0;
         end else if (mem_we_ff) begin
            addr_ff <= (addr_ff == LAST_A) ? '0 : addr_ff + 1'b1;
         end
         if (st_ff == CSD_WAIT && trigger_event) begin
            tpos_ff <= (addr_ff >= PIPE_A) ? addr_ff - PIPE_A : addr_ff + ADDR_W'(REC_DEPTH) - PIPE_A; // R4
         end
      end
   end

   // Timing lines show raw channels; sense never applies here
   generate
      for (genvar g = 0; g < CSD_LINES; g++) begin : g_line
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               tbits_ff[g] <= 1'b0;
            end else begin
               tbits_ff[g] <= !tline_ff[g][CSD_TL_BLANK] && dat_s2_ff[tline_ff[g][4:0]]; // R8 R13
            end
         end
      end
   endgenerate

   // State and trigger view fields
   generate
      for (genvar f = 0; f < CSD_FIELDS; f++) begin : g_field
         csd_field_xtr u_xtr (
            .smp(dat_s2_ff),
            .lo(lo_ff[f]),
            .hi(hi_ff[f]),
            .sense_complemented(sense_ff[f]),
            .val(fraw[f])
         );
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               fval_ff[f] <= 22'h0;
            end else begin
               fval_ff[f] <= (base_ff[f] == CSD_BASE_OFF) ? 22'h0 : fraw[f]; // R12 R9
            end
         end
         assign field_val[f*22 +: 22] = fval_ff[f];
         assign field_on[f] = base_ff[f] != CSD_BASE_OFF;
         assign field_base[f*4 +: 4] = base_ff[f];
      end
   endgenerate

   // Outputs straight from flops
   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign mem_we = mem_we_ff;
   assign mem_addr = addr_ff;
   assign mem_wdata = mem_wdata_ff;
   assign timing_bits = tbits_ff;
   assign acq_done = st_ff[2]; // DONE alone has bit 2
endmodule
`default_nettype wire

/* File: testbench/csd_capture_assertions.sv */
// Port checker for the capture block.
// Assumes a bind into csd_capture, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module csd_capture_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [1:0] rresp,
   // Storage and views
   input wire logic mem_we,
   input wire logic acq_done,
   input wire logic [175:0] field_val,
   input wire logic [7:0] field_on,
   input wire logic [31:0] field_base
);
   import csd_pkg::*;
   logic [7:0] on_exp;
   logic [175:0] off_mask;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Enables from base codes; off fields masked
   always_comb begin
      for (int f = 0; f < 8; f++) begin
         on_exp[f] = field_base[f*4+:4] != CSD_BASE_OFF;
         off_mask[f*22+:22] = {22{~on_exp[f]}};
      end
   end
   // One answer per request, on time
   a_aw_hold: assert property (awvalid && awready |=> !awready) else $error("aw taken twice");
   a_b_soon: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid) else $error("no bvalid");
   a_b_once: assert property (bvalid && bready |=> !bvalid) else $error("bvalid repeated");
   a_r_soon: assert property (arvalid && arready |=> rvalid && !arready) else $error("no rvalid");
   a_r_once: assert property (rvalid && rready |=> !rvalid) else $error("rvalid repeated");
   // Slow probe edges: a write never lasts two cycles
   a_we_pulse: assert property (mem_we |=> !mem_we) else $error("write too long");
   a_done_quiet: assert property (acq_done && $past(acq_done) |-> !mem_we) else $error("write after done");
   // Value flop lags its enable by a cycle
   a_on_decode: assert property (field_on == on_exp) else $error("field enable wrong");
   a_off_zero: assert property ((field_val & off_mask & $past(off_mask)) == '0) else $error("off field set");
   c_store: cover property (mem_we);
   c_done: cover property ($rose(acq_done));
   c_slverr: cover property (rvalid && rresp == CSD_SLVERR);
endmodule
bind csd_capture csd_capture_chk u_chk (.*);
`default_nettype wire

/* File: testbench/csd_probe_model.sv */
// Target system seen through the probes.
// Assumes the bench calls pulses per burst; clock rests low between.
`timescale 1ns/1ps
`default_nettype none
module csd_probe_model (
   // Probe pins
   output logic probe_clk,
   output logic clk_qual,
   output logic data_qual,
   output logic [31:0] probe_data
);
   // Idle pins
   initial begin
      probe_clk = 1'b0;
      clk_qual = 1'b0;
      data_qual = 1'b0;
      probe_data = 32'h0;
   end
   // Edges 80 ns apart, well above two aclk per phase
   task automatic pulses(input int n, input logic cq, input logic dq, input logic [31:0] d);
      repeat (n) begin
         clk_qual = cq;
         data_qual = dq;
         probe_data = d;
         #24 probe_clk = 1'b1;
         #40 probe_clk = 1'b0;
         #16;
      end
      clk_qual = 1'b0;
      data_qual = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: testbench/csd_capture_bench.sv */
// Self-checking bench for the capture block.
// Assumes csd_pkg and the probe model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module csd_capture_bench;
   import csd_pkg::*;
   localparam int DEPTH = 20;
   localparam logic [31:0] QS [4] = '{CSD_Q4, CSD_Q8, CSD_Q16, CSD_Q32};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, trigger_event = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, seed = 32'd33525, v;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, probe_clk, clk_qual, data_qual, mem_we, acq_done;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, probe_data, mem_wdata, field_base;
   logic [9:0] mem_addr;
   logic [11:0] timing_bits;
   logic [175:0] field_val;
   logic [7:0] field_on;
   int failures = 0, check_count = 0, we_cnt = 0, n0;
   csd_capture #(.REC_DEPTH(DEPTH)) u_csd_capture (.*);
   csd_probe_model u_csd_probe_model (.*);
   initial begin
      forever #4 aclk = ~aclk;
   end
   // Stored samples, checked as differences
   always @(posedge aclk) if (mem_we === 1'b1) we_cnt <= we_cnt + 1;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Delay rounded down to the width's step
   function automatic logic [31:0] rnd(input logic [31:0] d, input logic [1:0] m);
      return d - d % QS[m];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Address and data offered together; bready stays high
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      chk(32'(bresp), 0);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      chk(32'(rresp), 32'(er));
      chk(rdata, exp);
   endtask
   // Fresh data; time for the synchroniser
   task automatic burst(input int n, input logic cq, input logic dq);
      v = xs();
      u_csd_probe_model.pulses(n, cq, dq, v);
      repeat (8) @(posedge aclk);
   endtask
   task automatic tally_and_finish();
      $display("TB: %0d checks, %0d failures", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #300000;
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(field_base, 32'hffff_ffff);
      chk({20'h0, field_on, timing_bits}, 32'h0);
      for (int m = 0; m < 4; m++) begin
         v = xs() & 32'h000f_ffff;
         wr(CSD_CTRL, 32'(m << 2));
         wr(CSD_DELAY, v);
         rdchk(CSD_DELAY, rnd(v, 2'(m)), CSD_OKAY);
      end
      wr(CSD_START, 32'd13);
      rdchk(CSD_DELAY, rnd(DEPTH + 13, 2'd3), CSD_OKAY);
      wr(CSD_START, 32'h8000_0005);
      rdchk(CSD_START, 32'h8000_0005, CSD_OKAY);
      rdchk(8'h1c, 32'h0, CSD_SLVERR);
      $display("TB: delay test done");
      wr(CSD_FIELD, 32'h0004_030e);
      rdchk(CSD_STAT, 32'h10, CSD_OKAY);
      wr(CSD_STAT, 32'h10);
      wr(CSD_FIELD, 32'h0000_160b);
      rdchk(CSD_STAT, 32'h10, CSD_OKAY);
      wr(CSD_STAT, 32'h10);
      wr(CSD_FIELD, 32'h0000_150b);
      rdchk(CSD_STAT, 32'h0, CSD_OKAY);
      wr(CSD_FIELD + 8'h04, 32'h0104_0b0e);
      wr(CSD_TLINE, 32'h8080_0505);
      for (int b = 9; b < 16; b++) begin
         wr(CSD_FIELD + 8'h08, 32'(b));
         chk(field_base[11:8], (b < 10) ? CSD_BASE_OFF : 4'(b));
      end
      burst(1, 1'b1, 1'b1);
      chk(field_val[21:0], v[21:0]);
      chk(field_val[43:22], {14'h0, ~v[11:4]});
      chk(timing_bits, {10'h0, v[5], v[5]});
      $display("TB: field test done");
      wr(CSD_DELAY, 32'd40);
      wr(CSD_CTRL, 32'h0000_000d);
      n0 = we_cnt;
      burst(5, 1'b1, 1'b1);
      chk(we_cnt - n0, 5);
      trigger_event <= 1'b1;
      @(posedge aclk);
      trigger_event <= 1'b0;
      n0 = we_cnt;
      burst(3, 1'b1, 1'b0);
      burst(3, 1'b0, 1'b1);
      chk(we_cnt - n0, 0);
      burst(23, 1'b1, 1'b1);
      chk(we_cnt - n0, 23);
      chk(acq_done, 1'b1);
      chk({22'h0, mem_addr}, (5 + 23) % DEPTH);
      chk(mem_wdata, v);
      burst(2, 1'b1, 1'b1);
      chk(we_cnt - n0, 23);
      rdchk(CSD_PRE, 32'd5, CSD_OKAY);
      rdchk(CSD_TPOS, (5 + DEPTH - CSD_PIPE_CLKS) % DEPTH, CSD_OKAY);
      wr(CSD_CTRL, 32'h0000_000d);
      burst(1, 1'b1, 1'b1);
      wr(CSD_CTRL, 32'h0000_000e);
      burst(1, 1'b0, 1'b0);
      chk(acq_done, 1'b0);
      burst(1, 1'b0, 1'b0);
      chk(acq_done, 1'b1);
      $display("TB: capture test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
